// ### logic/return_rotate_sleep_exec.v
// Return, rotate and sleep execution core with an AXI4-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
`include "return_rotate_sleep_regs.vh"
module return_rotate_sleep_exec
(
  // Clock and asynchronous active-low reset.
  input  wire        clk,
  input  wire        rst_n,
  // AXI4-Lite write address channel.
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data channel.
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response channel.
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address channel.
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data channel.
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // Core state.
  output wire        sleeping,
  output wire        busy
);

  // Execution states.
  localparam [1:0] S_IDLE   = 2'h0;
  localparam [1:0] S_EXEC   = 2'h1;
  localparam [1:0] S_SECOND = 2'h2;

  // Bus slave state.
  reg  [7:0]  awAddr_reg;   // Captured write address.
  reg         awHeld_reg;   // Write address waiting for its data.
  reg  [31:0] wData_reg;    // Captured write data.
  reg  [3:0]  wStrb_reg;    // Captured byte strobes.
  reg         wHeld_reg;    // Write data waiting for its address.
  reg         awReady_reg;  // Address channel open.
  reg         wReady_reg;   // Data channel open.
  reg         bValid_reg;   // Response pending.
  reg  [1:0]  bResp_reg;    // Response code.
  reg         arReady_reg;  // Read address channel open.
  reg         rValid_reg;   // Read data pending.
  reg  [31:0] rData_reg;    // Read data word.
  reg  [1:0]  rResp_reg;    // Read response code.

  // Core state.
  reg  [1:0]  state_reg;    // Execution state.
  reg  [23:0] instr_reg;    // Instruction being or last executed.
  reg  [7:0]  w_reg;        // Working register.
  reg         carry_reg;    // Carry flag.
  reg         powerDownN_reg; // Power-down flag, active low.
  reg         timeOutN_reg;   // Time-out flag, active low.
  reg         irqEnable_reg;  // Global interrupt enable.
  reg         under_reg;    // Sticky stack underflow.
  reg         over_reg;     // Sticky stack overflow.
  reg  [`PC_W-1:0] pc_reg;  // Program counter.
  reg  [6:0]  fAddr_reg;    // File pointer for software access.
  reg  [7:0]  file_reg [0:127]; // File registers.
  reg         sleep_reg;    // Core halted by sleep.
  reg  [7:0]  presc_reg;    // Watchdog prescaler.
  reg  [7:0]  wdog_reg;     // Watchdog count.
  reg         busy_reg;     // Mirror of a non-idle state.
  integer     i;

  // Stack wiring.
  wire [`PC_W-1:0] stackTop;
  wire [4:0]  depth;
  wire        stackOver;
  wire        stackUnder;

  // Decoded instruction.
  wire [2:0]  op      = instr_reg[`IN_OP];
  wire        dest    = instr_reg[`IN_DEST];
  wire [6:0]  fIdx    = instr_reg[`IN_FILE];
  wire [7:0]  fileVal = file_reg[fIdx];
  wire        inExec  = (state_reg == S_EXEC);
  wire        isRet   = (op == `OP_RETURN) | (op == `OP_RETLIT) |
                        (op == `OP_RETIRQ);
  wire        doPop   = inExec & isRet;
  wire        doSleep = inExec & (op == `OP_SLEEP);

  // Rotate through carry; result is {new carry, new byte}.
  function [8:0] rotateThrough;
    input [7:0] v;
    input       c;
    input       left;
    begin
      if (left)
        rotateThrough = {v[7], v[6:0], c};
      else
        rotateThrough = {v[0], c, v[7:1]};
    end
  endfunction

  wire [8:0] rotL = rotateThrough(fileVal, carry_reg, 1'b1);
  wire [8:0] rotR = rotateThrough(fileVal, carry_reg, 1'b0);

  // Word offsets 0x00 to 0x1C are decoded; anything else is an error.
  function isMapped;
    input [7:0] a;
    begin
      isMapped = (a[1:0] == 2'h0) && (a <= `OFS_WAKE);
    end
  endfunction

  // Readback of one register word, also the base for strobe merging.
  function [31:0] regWord;
    input [7:0] a;
    begin
      case (a)
        `OFS_INSTR:  regWord = {8'h00, instr_reg};
        `OFS_WREG:   regWord = {24'h00_0000, w_reg};
        `OFS_STATUS: regWord = {24'h00_0000, over_reg, under_reg,
                                sleep_reg, busy_reg, irqEnable_reg,
                                timeOutN_reg, powerDownN_reg, carry_reg};
        `OFS_PC:     regWord = {17'h0_0000, pc_reg};
        `OFS_STACK:  regWord = {11'h000, depth, 1'b0, stackTop};
        `OFS_FADDR:  regWord = {25'h000_0000, fAddr_reg};
        `OFS_FDATA:  regWord = {24'h00_0000, file_reg[fAddr_reg]};
        `OFS_WAKE:   regWord = {16'h0000, presc_reg, wdog_reg};
        default:     regWord = 32'h0000_0000;
      endcase
    end
  endfunction

  // Keeps unstrobed bytes at their current value.
  function [31:0] mergeBytes;
    input [31:0] oldV;
    input [31:0] newV;
    input [3:0]  strb;
    integer k;
    begin
      mergeBytes = oldV;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          mergeBytes[k*8 +: 8] = newV[k*8 +: 8];
    end
  endfunction

  // A new instruction is refused while one runs or the core sleeps.
  wire doWrite  = awHeld_reg & wHeld_reg & ~bValid_reg;
  wire refused  = (awAddr_reg == `OFS_INSTR) &
                  (busy_reg | sleep_reg);
  wire writeOk  = doWrite & isMapped(awAddr_reg) & ~refused;
  wire [31:0] merged = mergeBytes(regWord(awAddr_reg), wData_reg, wStrb_reg);

  function wrSel;
    input [7:0] ofs;
    begin
      wrSel = writeOk && (awAddr_reg == ofs);
    end
  endfunction

  // Write side: each channel closes on its handshake and reopens after
  // the response is taken, so only one write is ever in flight.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awAddr_reg  <= 8'h00;
      awHeld_reg  <= 1'b0;
      wData_reg   <= 32'h0000_0000;
      wStrb_reg   <= 4'h0;
      wHeld_reg   <= 1'b0;
      awReady_reg <= 1'b1;
      wReady_reg  <= 1'b1;
      bValid_reg  <= 1'b0;
      bResp_reg   <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && awReady_reg)
      begin
        awAddr_reg  <= s_axi_awaddr;
        awHeld_reg  <= 1'b1;
        awReady_reg <= 1'b0;
      end
      if (s_axi_wvalid && wReady_reg)
      begin
        wData_reg  <= s_axi_wdata;
        wStrb_reg  <= s_axi_wstrb;
        wHeld_reg  <= 1'b1;
        wReady_reg <= 1'b0;
      end
      if (doWrite)
      begin
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
        bValid_reg <= 1'b1;
        // Refused instructions report an error so software can see them.
        bResp_reg  <= (isMapped(awAddr_reg) && !refused) ?
                      `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bValid_reg && s_axi_bready)
      begin
        bValid_reg  <= 1'b0;
        awReady_reg <= 1'b1;
        wReady_reg  <= 1'b1;
      end
    end
  end

  // Read side: data are sampled at the address handshake, no side effects.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arReady_reg <= 1'b1;
      rValid_reg  <= 1'b0;
      rData_reg   <= 32'h0000_0000;
      rResp_reg   <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && arReady_reg)
    begin
      arReady_reg <= 1'b0;
      rValid_reg  <= 1'b1;
      rData_reg   <= regWord(s_axi_araddr);
      rResp_reg   <= isMapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rValid_reg && s_axi_rready)
    begin
      rValid_reg  <= 1'b0;
      arReady_reg <= 1'b1;
    end
  end

  // Watchdog runs freely; sleep restarts both stages from zero.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc_reg <= 8'h00;
      wdog_reg  <= 8'h00;
    end
    else if (doSleep)
    begin
      presc_reg <= 8'h00;
      wdog_reg  <= 8'h00;
    end
    else
    begin
      presc_reg <= presc_reg + 8'h01;
      if (presc_reg == `PRESC_LAST)
        wdog_reg <= wdog_reg + 8'h01;
    end
  end

  // Software writes come first; the execution step below overrides them.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= S_IDLE;
      instr_reg <= 24'h00_0000;
      w_reg     <= `RST_WREG;
      carry_reg <= 1'b0;
      powerDownN_reg <= `RST_PDN;
      timeOutN_reg   <= `RST_TON;
      irqEnable_reg  <= 1'b0;
      under_reg <= 1'b0;
      over_reg  <= 1'b0;
      pc_reg    <= `RST_PC;
      fAddr_reg <= 7'h00;
      sleep_reg <= 1'b0;
      busy_reg  <= 1'b0;
      for (i = 0; i < 128; i = i + 1)
        file_reg[i] <= 8'h00;
    end
    else
    begin
      if (wrSel(`OFS_WREG))
        w_reg <= merged[7:0];
      if (wrSel(`OFS_PC))
        pc_reg <= merged[`PC_W-1:0];
      if (wrSel(`OFS_FADDR))
        fAddr_reg <= merged[6:0];
      if (wrSel(`OFS_FDATA))
        file_reg[fAddr_reg] <= merged[7:0];
      if (wrSel(`OFS_WAKE))
        sleep_reg <= 1'b0;
      if (wrSel(`OFS_STATUS))
      begin
        carry_reg <= merged[`ST_CARRY];
        powerDownN_reg <= merged[`ST_PDN];
        timeOutN_reg   <= merged[`ST_TON];
        irqEnable_reg  <= merged[`ST_IRQEN];
      end
      // Sticky faults clear on a one; a fault in the same cycle wins.
      under_reg <= (under_reg & ~(wrSel(`OFS_STATUS) &
                   merged[`ST_UNDER])) | stackUnder;
      over_reg  <= (over_reg & ~(wrSel(`OFS_STATUS) &
                   merged[`ST_OVER])) | stackOver;
      case (state_reg)
        S_IDLE:
        begin
          if (wrSel(`OFS_INSTR))
          begin
            instr_reg <= merged[23:0];
            state_reg <= S_EXEC;
            busy_reg  <= 1'b1;
          end
        end
        S_EXEC:
        begin
          state_reg <= S_IDLE;
          busy_reg  <= 1'b0;
          case (op)
            `OP_RETURN, `OP_RETLIT, `OP_RETIRQ:
            begin
              pc_reg    <= stackTop;
              state_reg <= S_SECOND;
              busy_reg  <= 1'b1;
              if (op == `OP_RETLIT)
                w_reg <= instr_reg[`IN_LIT];
              if (op == `OP_RETIRQ)
                irqEnable_reg <= 1'b1;
            end
            `OP_ROTL:
            begin
              carry_reg <= rotL[8];
              if (dest)
                file_reg[fIdx] <= rotL[7:0];
              else
                w_reg <= rotL[7:0];
            end
            `OP_ROTR:
            begin
              carry_reg <= rotR[8];
              if (dest)
                file_reg[fIdx] <= rotR[7:0];
              else
                w_reg <= rotR[7:0];
            end
            `OP_SLEEP:
            begin
              powerDownN_reg <= 1'b0;
              timeOutN_reg   <= 1'b1;
              sleep_reg <= 1'b1;
            end
            default:
            begin
              // Unknown opcodes retire in one cycle with no effect.
              state_reg <= S_IDLE;
            end
          endcase
        end
        S_SECOND:
        begin
          // Second instruction cycle of a return, the flushed fetch.
          state_reg <= S_IDLE;
          busy_reg  <= 1'b0;
        end
        default:
        begin
          state_reg <= S_IDLE;
          busy_reg  <= 1'b0;
        end
      endcase
    end
  end

  // Return stack; pushes come from software, pops from the returns.
  return_stack stack
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .push      (wrSel(`OFS_STACK)),
    .pushData  (merged[`PC_W-1:0]),
    .pop       (doPop),
    .stackTop  (stackTop),
    .depth     (depth),
    .overflow  (stackOver),
    .underflow (stackUnder)
  );

  // Every output is a flip-flop.
  assign s_axi_awready = awReady_reg;
  assign s_axi_wready  = wReady_reg;
  assign s_axi_bresp   = bResp_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_arready = arReady_reg;
  assign s_axi_rdata   = rData_reg;
  assign s_axi_rresp   = rResp_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign sleeping      = sleep_reg;
  assign busy          = busy_reg;

endmodule // return_rotate_sleep_exec
`default_nettype wire

// ### logic/return_rotate_sleep_regs.vh
// Register map, field layout, reset values and opcodes of the core block.
//
// Behaviour
// - Literal return loads literal into W, flags untouched.
// - Literal return pops stack into PC, two cycles.
// - Plain return pops stack into PC, two cycles.
// - Rotate left through carry, bit seven to carry.
// - Rotate left destination: 0 W, 1 file.
// - Rotate right through carry, bit zero to carry.
// - Rotate right destination: 0 W, 1 file.
// - Sleep clears watchdog count and its prescaler.
// - Sleep clears power-down flag, sets time-out flag.
// - Interrupt return pops stack, sets interrupt enable.
`ifndef RETURN_ROTATE_SLEEP_REGS_VH
`define RETURN_ROTATE_SLEEP_REGS_VH

// Byte offsets of the register words.
`define OFS_INSTR   8'h00
`define OFS_WREG    8'h04
`define OFS_STATUS  8'h08
`define OFS_PC      8'h0C
`define OFS_STACK   8'h10
`define OFS_FADDR   8'h14
`define OFS_FDATA   8'h18
`define OFS_WAKE    8'h1C

// Opcodes held in the instruction word.
`define OP_RETURN   3'h0
`define OP_RETLIT   3'h1
`define OP_RETIRQ   3'h2
`define OP_ROTL     3'h3
`define OP_ROTR     3'h4
`define OP_SLEEP    3'h5

// Instruction word fields.
`define IN_OP       2:0
`define IN_DEST     7
`define IN_FILE     14:8
`define IN_LIT      23:16

// Status word bit positions.
`define ST_CARRY    0
`define ST_PDN      1
`define ST_TON      2
`define ST_IRQEN    3
`define ST_BUSY     4
`define ST_SLEEP    5
`define ST_UNDER    6
`define ST_OVER     7

// Reset values.
`define RST_WREG    8'h00
`define RST_PC      15'h0000
`define RST_PDN     1'b1
`define RST_TON     1'b1

// Sizes and timing.
`define PC_W        15
`define STACK_DEPTH 16
`define PRESC_LAST  8'hFF

// AXI responses.
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// ### logic/return_stack.v
// Sixteen-level hardware return stack with push, pop and fault pulses.
`timescale 1ns/1ps
`default_nettype none
`include "return_rotate_sleep_regs.vh"
module return_stack
(
  // Clock and reset.
  input  wire                 clk,
  input  wire                 rst_n,
  // Push and pop requests.
  input  wire                 push,
  input  wire [`PC_W-1:0]     pushData,
  input  wire                 pop,
  // Current top, fill level and fault pulses.
  output wire [`PC_W-1:0]     stackTop,
  output wire [4:0]           depth,
  output wire                 overflow,
  output wire                 underflow
);

  reg  [`PC_W-1:0] entry_reg [0:`STACK_DEPTH-1]; // Stored addresses.
  reg  [4:0]       ptr_reg;                       // Number of entries.
  wire [4:0]       ptrDec = ptr_reg - 5'h01;      // Index of the top.
  integer          i;

  // An empty stack shows zero so a stray pop lands the PC at reset vector.
  assign stackTop  = (ptr_reg == 5'h00) ? {`PC_W{1'b0}} :
                     entry_reg[ptrDec[3:0]];
  assign depth     = ptr_reg;
  assign overflow  = push & ~pop & (ptr_reg == 5'h10);
  assign underflow = pop & (ptr_reg == 5'h00);

  // Pop wins over push; a push onto a full stack is dropped, not wrapped.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr_reg <= 5'h00;
      for (i = 0; i < `STACK_DEPTH; i = i + 1)
        entry_reg[i] <= {`PC_W{1'b0}};
    end
    else if (pop)
    begin
      if (ptr_reg != 5'h00)
        ptr_reg <= ptrDec;
    end
    else if (push && ptr_reg != 5'h10)
    begin
      entry_reg[ptr_reg[3:0]] <= pushData;
      ptr_reg <= ptr_reg + 5'h01;
    end
  end

endmodule // return_stack
`default_nettype wire

// ### verif/return_rotate_sleep_exec_assertions.sv
// Concurrent checks on the bus and execution ports of the core.
`timescale 1ns/1ps
`default_nettype none
`include "return_rotate_sleep_regs.vh"
module return_rotate_sleep_exec_assertions
(
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst_n,
  // Write address and data channels.
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  // Write response channel.
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read channels.
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Core state.
  input wire logic        sleeping,
  input wire logic        busy
);
  // Everything here runs on one clock and is quiet during reset.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Address and data of a full write taken at the same edge.
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // A full instruction word written while the core can accept it.
  sequence instrTaken;
    wrTaken ##0 s_axi_awaddr == `OFS_INSTR && s_axi_wstrb == 4'hF &&
      !busy && !sleeping;
  endsequence
  // Busy shapes of the two-cycle and one-cycle instructions.
  sequence twoBusy;
    busy ##1 busy ##1 !busy;
  endsequence
  sequence oneBusy;
    busy ##1 !busy;
  endsequence

  chk_return_busy:
  assert property (instrTaken ##0 s_axi_wdata[`IN_OP] <= `OP_RETIRQ
    |-> ##2 twoBusy) else $error("Return did not take two cycles.");
  chk_rotate_busy:
  assert property (instrTaken ##0 (s_axi_wdata[`IN_OP] == `OP_ROTL ||
    s_axi_wdata[`IN_OP] == `OP_ROTR) |-> ##2 oneBusy)
    else $error("Rotate did not take one cycle.");
  chk_sleep_enters:
  assert property (instrTaken ##0 s_axi_wdata[`IN_OP] == `OP_SLEEP
    |-> ##2 busy ##1 (sleeping && !busy)) else $error("Sleep not entered.");
  chk_sleep_idle:
  assert property (sleeping |-> !busy) else $error("Busy while asleep.");
  chk_sleep_refuse:
  assert property (wrTaken ##0 s_axi_awaddr == `OFS_INSTR && sleeping
    |-> ##[1:2] s_axi_bvalid && s_axi_bresp == `RESP_SLVERR)
    else $error("Instruction accepted while asleep.");
  chk_write_answer:
  assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
    else $error("Write response missing.");
  chk_read_answer:
  assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read data missing.");
  chk_rdata_stands:
  assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("Read data moved.");
  chk_bresp_stands:
  assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("Response moved.");
endmodule // return_rotate_sleep_exec_assertions

// Attach the checker to every instance of the core.
bind return_rotate_sleep_exec return_rotate_sleep_exec_assertions chk (
  .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sleeping, .busy);
`default_nettype wire

// ### verif/return_rotate_sleep_exec_tb.sv
// Self-checking bench for the return, rotate and sleep core.
`timescale 1ns/1ps
`default_nettype none
`include "return_rotate_sleep_regs.vh"
module return_rotate_sleep_exec_tb;
  // Bench-driven inputs of the core.
  logic        clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  // Outputs of the core.
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, sleeping, busy;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  // Counters and the last bus answer.
  int          nMismatch, numChecks;
  logic [31:0] rd;
  logic [1:0]  resp;
  // Rotation cases: opcode, destination, carry in, source, result, carry.
  logic [2:0]  rOp [4] = '{`OP_ROTL, `OP_ROTL, `OP_ROTR, `OP_ROTR};
  logic        rDst[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic        cIn [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic [7:0]  fIn [4] = '{8'hE6, 8'h80, 8'h01, 8'h02};
  logic [7:0]  res [4] = '{8'hCC, 8'h01, 8'h80, 8'h01};
  logic        cOut[4] = '{1'b1, 1'b1, 1'b1, 1'b0};

  return_rotate_sleep_exec uut (
    .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sleeping, .busy);

  // A 50 ns clock.
  always #25 clk = ~clk;

  // Compares a value with its expectation and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Offers address and data together and drops each once it is taken.
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(awDone && wDone))
    begin
      @(posedge clk);
      awDone = awDone || s_axi_awready === 1'b1;
      wDone = wDone || s_axi_wready === 1'b1;
      if (awDone)
        s_axi_awvalid <= 1'b0;
      if (wDone)
        s_axi_wvalid <= 1'b0;
    end
    // The response may not come at once, so wait for it edge by edge.
    // Ready rises only once it is seen, so a held response is exercised.
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge clk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Reads one word; rready rises once the data are seen and stays up
  // until the edge that takes them.
  task automatic axiRead(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge clk);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Reads a register and compares it.
  task automatic readCheck(input logic [7:0] a, input logic [31:0] exp);
    axiRead(a);
    check(rd, exp);
  endtask

  // Packs an instruction word.
  function automatic logic [31:0] instr(input logic [2:0] op,
    input logic dst, input logic [6:0] f, input logic [7:0] k);
    instr = {8'h00, k, 1'b0, f, dst, 4'h0, op};
  endfunction

  // Starts an instruction and waits until the core is idle again.
  task automatic run(input logic [31:0] w);
    axiWrite(`OFS_INSTR, w);
    check({30'h0000_0000, resp}, {30'h0000_0000, `RESP_OKAY});
    do @(posedge clk); while (busy !== 1'b0);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // A hang is cut off long after the sequence should have ended.
  initial
  begin
    repeat (6000) @(posedge clk);
    nMismatch++;
    finish_test;
  end

  // Main sequence.
  initial
  begin
    {clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0_0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    nMismatch = 0;
    numChecks = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    readCheck(`OFS_STATUS, 32'h0000_0006);
    // Rotations in both directions into both destinations at file 127.
    axiWrite(`OFS_FADDR, 32'h0000_007F);
    for (int i = 0; i < 4; i++)
    begin
      axiWrite(`OFS_WREG, 32'h0000_005A);
      axiWrite(`OFS_FDATA, {24'h00_0000, fIn[i]});
      axiWrite(`OFS_STATUS, {29'h0000_0000, 2'b11, cIn[i]});
      run(instr(rOp[i], rDst[i], 7'h7F, 8'h00));
      readCheck(`OFS_STATUS, {29'h0000_0000, 2'b11, cOut[i]});
      readCheck(`OFS_WREG, rDst[i] ? 32'h0000_005A : res[i]);
      readCheck(`OFS_FDATA, rDst[i] ? res[i] : fIn[i]);
    end
    // Three return kinds drain a stack of three addresses.
    axiWrite(`OFS_STATUS, 32'h0000_0006);
    axiWrite(`OFS_WREG, 32'h0000_0011);
    axiWrite(`OFS_STACK, 32'h0000_1234);
    axiWrite(`OFS_STACK, 32'h0000_0ABC);
    axiWrite(`OFS_STACK, 32'h0000_7FFF);
    run(instr(`OP_RETURN, 1'b0, 7'h00, 8'hA5));
    readCheck(`OFS_PC, 32'h0000_7FFF);
    readCheck(`OFS_WREG, 32'h0000_0011);
    run(instr(`OP_RETLIT, 1'b0, 7'h00, 8'hFF));
    readCheck(`OFS_PC, 32'h0000_0ABC);
    readCheck(`OFS_WREG, 32'h0000_00FF);
    readCheck(`OFS_STATUS, 32'h0000_0006);
    // Spare codes retire as no-ops and leave W and the stack alone.
    run(instr(3'h6, 1'b0, 7'h7F, 8'h44));
    readCheck(`OFS_WREG, 32'h0000_00FF);
    run(instr(`OP_RETIRQ, 1'b0, 7'h00, 8'h00));
    readCheck(`OFS_PC, 32'h0000_1234);
    readCheck(`OFS_STATUS, 32'h0000_000E);
    readCheck(`OFS_STACK, 32'h0000_0000);
    // Only the strobed byte of a narrow write lands.
    s_axi_wstrb <= 4'h2;
    axiWrite(`OFS_PC, 32'hFFFF_56FF);
    s_axi_wstrb <= 4'hF;
    readCheck(`OFS_PC, 32'h0000_5634);
    // Sleep once the watchdog has moved away from zero.
    axiWrite(`OFS_STATUS, 32'h0000_0002);
    repeat (600) @(posedge clk);
    axiRead(`OFS_WAKE);
    check(32'(rd[7:0] != 8'h00), 32'h0000_0001);
    run(instr(`OP_SLEEP, 1'b0, 7'h00, 8'h00));
    check({31'h0000_0000, sleeping}, 32'h0000_0001);
    readCheck(`OFS_STATUS, 32'h0000_0024);
    axiRead(`OFS_WAKE);
    check(32'(rd[7:0]), 32'h0000_0000);
    check(32'(rd[15:8] < 8'h20), 32'h0000_0001);
    // An instruction offered while asleep must be turned away.
    axiWrite(`OFS_INSTR, instr(`OP_RETLIT, 1'b0, 7'h00, 8'h33));
    check({30'h0000_0000, resp}, {30'h0000_0000, `RESP_SLVERR});
    readCheck(`OFS_WREG, 32'h0000_00FF);
    axiWrite(`OFS_WAKE, 32'h0000_0001);
    check({31'h0000_0000, sleeping}, 32'h0000_0000);
    // An unmapped word answers with an error and reads zero.
    axiRead(8'h20);
    check({resp, rd[29:0]}, {`RESP_SLVERR, 30'h0000_0000});
    finish_test;
  end
endmodule // return_rotate_sleep_exec_tb
`default_nettype wire
